// >>> rtl/vwd_pkg.sv
package vwd_pkg;
   // Bit n of the documented 64-bit numbering maps to word bit (63 - n)
   localparam int WORD_W = 16;
   localparam int COORD_W = 9;
   localparam int CHAR_W = 6;
   // Data code digits in the top octal digit (bits 11..9) of a 12-bit channel word
   localparam logic [2:0] CODE_X = 3'h6;
   localparam logic [2:0] CODE_Y = 3'h7;
   localparam logic [2:0] CODE_CONNECT = 3'h7;
   // 16-bit mode function word fields
   localparam logic [7:0] ASC_CONNECT = 8'h0E;
   localparam logic [7:0] ASC_EITHER = 8'h0F;
   localparam logic [15:0] ASC_CHAR_SMALL = 16'h0E04;
   localparam logic [15:0] ASC_CHAR_MED = 16'h0E05;
   localparam logic [15:0] ASC_CHAR_LARGE = 16'h0E06;
   localparam logic [15:0] ASC_KBD = 16'h0E14;
   localparam logic [3:0] ASC_DOT_NIB = 4'h8;
   localparam logic [3:0] ASC_RIGHT_NIB = 4'h4;
   // Wishbone register byte addresses
   localparam logic [3:0] ADR_FUNC = 4'h0;
   localparam logic [3:0] ADR_DATA = 4'h4;
   localparam logic [3:0] ADR_STATUS = 4'h8;
   localparam logic [3:0] ADR_COORD = 4'hC;
   // Function register layout (our own compact form)
   localparam int FR_W = 7;
   localparam logic [FR_W-1:0] FR_RESET = 7'h00;
   // Size increments in X positions
   localparam logic [COORD_W-1:0] INC_SMALL = 9'h008;
   localparam logic [COORD_W-1:0] INC_MED = 9'h010;
   localparam logic [COORD_W-1:0] INC_LARGE = 9'h020;
   // Timing chain
   localparam int CLK_NS = 10;
   localparam int CHAIN_LEN = 32;
   localparam logic [4:0] T_INC_X = 5'h19;
   localparam logic [4:0] T_TEN = 5'h0A;
   localparam int DOT_PULSE_NS = 400;
   localparam int DOT_CYC_INT = (DOT_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [5:0] DOT_CYC = DOT_CYC_INT[5:0];
   // Stroke table depth per character
   localparam int STROKES = 8;
   typedef enum logic [3:0] {
      VWD_IDLE = 4'h1,
      VWD_CHAR0 = 4'h2,
      VWD_CHAR1 = 4'h4,
      VWD_DOT = 4'h8
   } vwd_state_t;
endpackage

// >>> rtl/vwd_stroke_gen.sv
// Movement generator: decodes one stroke code into beam actions
module vwd_stroke_gen (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Stroke code
   input wire logic step_i,
   input wire logic [4:0] code_i,
   input wire logic start_i,
   // Beam state
   output logic unblank_o,
   output logic [4:0] dx_o,
   output logic [4:0] dy_o
);
   logic v_dir_q;
   logic h_dir_q;
   logic vert_move_bit_a;
   logic vert_move_bit_b;
   logic horiz_move_bit_a;
   logic horiz_move_bit_b;
   logic blank_bit;

   assign {vert_move_bit_a, vert_move_bit_b, horiz_move_bit_a,
           horiz_move_bit_b, blank_bit} = code_i;

   // Direction and blanking state, cleared while idle, so fresh for each character pair
   always_ff @(posedge clk_i) begin
      if (rst_i || start_i) begin
         v_dir_q <= 1'b0;
         h_dir_q <= 1'b0;
         unblank_o <= 1'b0;
      end else if (step_i) begin
         if (blank_bit) begin
            unblank_o <= ~unblank_o;
         end
         if (vert_move_bit_a && vert_move_bit_b) begin
            v_dir_q <= ~v_dir_q;
         end
         if (horiz_move_bit_a && horiz_move_bit_b) begin
            h_dir_q <= ~h_dir_q;
         end
      end
   end

   // Beam offset inside the cell, 5 bits covers a large cell
   always_ff @(posedge clk_i) begin
      if (rst_i || start_i) begin
         dx_o <= 5'h00;
         dy_o <= 5'h00;
      end else if (step_i) begin
         if (vert_move_bit_b && !vert_move_bit_a) begin
            dy_o <= v_dir_q ? dy_o - 5'h01 : dy_o + 5'h01;
         end
         if (horiz_move_bit_a && !horiz_move_bit_b) begin
            dx_o <= h_dir_q ? dx_o - 5'h01 : dx_o + 5'h01;
         end else if (horiz_move_bit_b && !horiz_move_bit_a) begin
            dx_o <= h_dir_q ? dx_o - 5'h02 : dx_o + 5'h02;
         end
      end
   end
endmodule // vwd_stroke_gen

// >>> rtl/vwd_decoder.sv
module vwd_decoder (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   output logic err_o,
   // Console keyboard
   input wire logic key_down_i,
   input wire logic [5:0] key_data_i,
   // Console outputs
   output logic [8:0] x_coord_o,
   output logic [8:0] y_coord_o,
   output logic size_small_o,
   output logic size_medium_o,
   output logic size_large_o,
   output logic screen_right_o,
   output logic astig_o,
   output logic unblank_left_o,
   output logic unblank_right_o,
   output logic [4:0] beam_dx_o,
   output logic [4:0] beam_dy_o
);
   // Function register: {ascii, either, right, kbd, dot, large, medium}
   logic [vwd_pkg::FR_W-1:0] func_q;
   logic connected_q;
   logic [15:0] stage_q;
   logic full_q; // delayed full: a data word sits in staging
   logic kbd_full_q;
   logic [5:0] kbd_buf_q;
   logic key_down_q;
   logic dot_q;
   logic [5:0] dot_cnt_q;
   logic [4:0] chain_q;
   logic [2:0] stroke_q;
   logic sel_q;
   logic kbd_pulse_q;
   vwd_pkg::vwd_state_t state_q;
   logic wr;
   logic rd;
   logic hit;
   logic strobe_x;
   logic strobe_y;
   logic is_char;
   logic timing_phase_ten_clock;
   logic inc_x;
   logic [5:0] cur_char;
   logic [4:0] stroke_code;
   logic char_start;
   logic stroke_step;
   logic [8:0] x_inc;
   logic [8:0] x_mux;
   logic disp_dot;
   logic mode_dot;
   logic mode_kbd;
   logic func_wr;
   logic data_wr;
   logic busy;
   logic [15:0] asc_w;

   // Top digit of a 12-bit word (documented bits 52..54)
   function automatic logic [2:0] top_digit(input logic [15:0] w);
      return w[11:9];
   endfunction

   // Simple stroke table: bit pattern per step from character code
   function automatic logic [4:0] stroke_rom(input logic [5:0] ch,
                                             input logic [2:0] st);
      logic [4:0] r;
      r = 5'h00;
      if (ch != 6'h00) begin
         case (st)
            3'h0: r = 5'h01;
            3'h1: r = {1'b0, ch[0], 1'b0, 1'b0, 1'b0};
            3'h2: r = {1'b0, 1'b0, ch[1], 1'b0, 1'b0};
            3'h3: r = {1'b0, ch[2], 1'b0, 1'b0, 1'b0};
            3'h4: r = {1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
            3'h5: r = {1'b0, ch[3], 1'b0, ch[4], 1'b0};
            3'h6: r = {1'b0, 1'b0, ch[5], 1'b0, 1'b0};
            default: r = 5'h01; // unblank table: blank after char
         endcase
      end
      return r;
   endfunction

   assign mode_dot = func_q[2];
   assign mode_kbd = func_q[3];
   assign hit = cyc_i && stb_i && !ack_o && !err_o;
   assign wr = hit && we_i && (sel_i[1:0] == 2'h3);
   assign rd = hit && !we_i;
   assign busy = full_q || (state_q != vwd_pkg::VWD_IDLE);
   assign func_wr = wr && (adr_i == vwd_pkg::ADR_FUNC);
   assign data_wr = wr && (adr_i == vwd_pkg::ADR_DATA) && connected_q
                    && !busy;

   // Wishbone answers one cycle after the request; a data write waits while busy
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         err_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= hit && (adr_i == vwd_pkg::ADR_FUNC
                  || adr_i == vwd_pkg::ADR_STATUS
                  || adr_i == vwd_pkg::ADR_COORD
                  || (adr_i == vwd_pkg::ADR_DATA && (!we_i || !busy)));
         err_o <= hit && !(adr_i == vwd_pkg::ADR_FUNC
                  || adr_i == vwd_pkg::ADR_STATUS
                  || adr_i == vwd_pkg::ADR_COORD
                  || adr_i == vwd_pkg::ADR_DATA);
         dat_o <= 32'h0000_0000;
         if (rd) begin
            case (adr_i)
               vwd_pkg::ADR_FUNC: dat_o <= {24'h0, connected_q, func_q};
               vwd_pkg::ADR_DATA: dat_o <= {26'h0, kbd_full_q ?
                                   kbd_buf_q : 6'h00};
               vwd_pkg::ADR_STATUS: dat_o <= {28'h0, busy, dot_q,
                                     kbd_full_q, connected_q};
               vwd_pkg::ADR_COORD: dat_o <= {7'h0, y_coord_o, 7'h0,
                                    x_coord_o};
               default: dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Form marker in bit 15 is not part of the 16-bit code itself
   assign asc_w = {1'b0, dat_i[14:0]};

   // Function word decode, 12-bit or 16-bit form (bit 15 picks form)
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         func_q <= vwd_pkg::FR_RESET;
         connected_q <= 1'b0;
      end else if (func_wr) begin
         if (!dat_i[15]) begin
            connected_q <= top_digit(dat_i[15:0]) == vwd_pkg::CODE_CONNECT;
            if (top_digit(dat_i[15:0]) == vwd_pkg::CODE_CONNECT) begin
               func_q <= {1'b0, dat_i[8], dat_i[6], dat_i[4], dat_i[3],
                          dat_i[1], dat_i[0]};
            end
         end else begin
            connected_q <= asc_w[15:8] == vwd_pkg::ASC_CONNECT
                        || asc_w[15:8] == vwd_pkg::ASC_EITHER;
            if (asc_w[15:8] == vwd_pkg::ASC_CONNECT
                || asc_w[15:8] == vwd_pkg::ASC_EITHER) begin
               func_q[6] <= 1'b1;
               func_q[5] <= asc_w[15:8] == vwd_pkg::ASC_EITHER;
               func_q[4] <= dat_i[7:4] == vwd_pkg::ASC_RIGHT_NIB;
               func_q[3] <= asc_w == vwd_pkg::ASC_KBD;
               // Dot also from this form, when the low nibble is 8
               func_q[2] <= dat_i[3:0] == vwd_pkg::ASC_DOT_NIB;
               func_q[1] <= asc_w == vwd_pkg::ASC_CHAR_LARGE;
               func_q[0] <= asc_w == vwd_pkg::ASC_CHAR_MED;
            end
         end
      end
   end

   // Size decode to console and adder
   assign size_large_o = func_q[1];
   assign size_medium_o = func_q[0] && !func_q[1];
   assign size_small_o = !func_q[0] && !func_q[1];
   assign screen_right_o = func_q[4];

   // Staging register and delayed full
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stage_q <= 16'h0000;
         full_q <= 1'b0;
      end else begin
         full_q <= data_wr;
         if (data_wr) begin
            stage_q <= dat_i[15:0];
         end
      end
   end

   assign strobe_x = full_q && !mode_kbd
                     && top_digit(stage_q) == vwd_pkg::CODE_X;
   assign strobe_y = full_q && !mode_kbd
                     && top_digit(stage_q) == vwd_pkg::CODE_Y;
   assign is_char = full_q && !mode_kbd && !mode_dot && !strobe_x
                    && !strobe_y;

   // Timing chain, free running
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         chain_q <= 5'h00;
      end else begin
         chain_q <= chain_q + 5'h01;
      end
   end

   // Strobe X bypasses the chain wait since the word is present now
   assign timing_phase_ten_clock = (chain_q == vwd_pkg::T_TEN) || strobe_x;
   // Every character ends with an advance, the first one included
   assign inc_x = (state_q != vwd_pkg::VWD_IDLE)
                  && (stroke_q == 3'(vwd_pkg::STROKES - 1))
                  && (chain_q == vwd_pkg::T_INC_X);

   // Position adder, wraps at 512
   always_comb begin
      x_inc = vwd_pkg::INC_SMALL;
      if (size_large_o) begin
         x_inc = vwd_pkg::INC_LARGE;
      end else if (size_medium_o) begin
         x_inc = vwd_pkg::INC_MED;
      end
   end
   // Adder covers bits 58..60 and carries into counter
   assign x_mux = strobe_x ? {stage_q[8:6], stage_q[5:0]}
                           : x_coord_o + x_inc;

   // X register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         x_coord_o <= 9'h000;
      end else if ((strobe_x && timing_phase_ten_clock)
                   || inc_x) begin
         x_coord_o <= x_mux;
      end
   end

   // Y register holds until next Y word
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         y_coord_o <= 9'h000;
      end else if (strobe_y) begin
         y_coord_o <= stage_q[8:0];
      end
   end

   // Character sequencer: two characters, each a run of strokes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= vwd_pkg::VWD_IDLE;
         stroke_q <= 3'h0;
         sel_q <= 1'b0;
      end else begin
         case (state_q)
            vwd_pkg::VWD_IDLE: begin
               stroke_q <= 3'h0;
               sel_q <= 1'b0;
               if (is_char) begin
                  state_q <= vwd_pkg::VWD_CHAR0;
               end
            end
            vwd_pkg::VWD_CHAR0, vwd_pkg::VWD_CHAR1: begin
               if (stroke_q != 3'(vwd_pkg::STROKES - 1)) begin
                  stroke_q <= stroke_q + 3'h1;
               end else if (chain_q == vwd_pkg::T_INC_X) begin
                  stroke_q <= 3'h0;
                  if (state_q == vwd_pkg::VWD_CHAR0) begin
                     state_q <= vwd_pkg::VWD_CHAR1;
                     sel_q <= 1'b1;
                  end else begin
                     state_q <= vwd_pkg::VWD_IDLE;
                     sel_q <= 1'b0;
                  end
               end
            end
            default: state_q <= vwd_pkg::VWD_IDLE;
         endcase
      end
   end

   // First X advance also happens between the two characters
   // Character selector
   assign cur_char = sel_q ? stage_q[5:0] : stage_q[11:6];
   assign stroke_code = stroke_rom(cur_char, stroke_q);
   assign char_start = (state_q == vwd_pkg::VWD_IDLE);
   assign stroke_step = (state_q != vwd_pkg::VWD_IDLE)
                        && (stroke_q != 3'(vwd_pkg::STROKES - 1));

   vwd_stroke_gen u_stroke (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .step_i(stroke_step),
      .code_i(stroke_code),
      .start_i(char_start),
      .unblank_o(),
      .dx_o(beam_dx_o),
      .dy_o(beam_dy_o)
   );

   // Dot flop and 400 ns unblank pulse
   assign disp_dot = mode_dot && strobe_y;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dot_q <= 1'b0;
         dot_cnt_q <= 6'h00;
      end else if (disp_dot) begin
         dot_q <= 1'b1;
         dot_cnt_q <= vwd_pkg::DOT_CYC;
      end else if (dot_cnt_q != 6'h00) begin
         dot_cnt_q <= dot_cnt_q - 6'h01;
      end else begin
         dot_q <= 1'b0;
      end
   end
   assign astig_o = dot_q;
   // Either-screen unblanks both
   assign unblank_left_o = (dot_cnt_q != 6'h00)
                           && (!func_q[4] || func_q[5]);
   assign unblank_right_o = (dot_cnt_q != 6'h00)
                            && (func_q[4] || func_q[5]);

   // Keyboard buffer; read of data port acts as inactivate
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         key_down_q <= 1'b0;
         kbd_full_q <= 1'b0;
         kbd_buf_q <= 6'h00;
         kbd_pulse_q <= 1'b0;
      end else begin
         key_down_q <= key_down_i;
         kbd_pulse_q <= rd && adr_i == vwd_pkg::ADR_DATA && mode_kbd;
         if (mode_kbd && key_down_i && !key_down_q) begin
            kbd_buf_q <= key_data_i;
            kbd_full_q <= 1'b1;
         end else if (kbd_pulse_q) begin
            kbd_full_q <= 1'b0;
         end
      end
   end
endmodule // vwd_decoder

// >>> tb/vwd_decoder_sva.sv
module vwd_decoder_sva (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Register bus
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   // Console side
   input wire logic [8:0] x_coord_o,
   input wire logic [8:0] y_coord_o,
   input wire logic size_small_o,
   input wire logic size_medium_o,
   input wire logic size_large_o,
   input wire logic astig_o,
   input wire logic unblank_left_o,
   input wire logic unblank_right_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic fw, xw, yw, unb;
   logic [8:0] dlo, inc;
   logic [6:0] hi_q;
   // Acked writes, split by target and data code
   assign fw = ack_o && we_i && adr_i == vwd_pkg::ADR_FUNC;
   assign xw = ack_o && we_i && adr_i == vwd_pkg::ADR_DATA
      && dat_i[11:9] == vwd_pkg::CODE_X;
   assign yw = ack_o && we_i && adr_i == vwd_pkg::ADR_DATA
      && dat_i[11:9] == vwd_pkg::CODE_Y;
   assign dlo = dat_i[8:0];
   assign unb = unblank_left_o || unblank_right_o;
   // Step follows the live size outputs; 9-bit sum wraps on its own
   assign inc = size_small_o ? vwd_pkg::INC_SMALL
      : size_medium_o ? vwd_pkg::INC_MED : vwd_pkg::INC_LARGE;
   // Length of the current unblank pulse
   always_ff @(posedge clk_i) begin
      if (rst_i || !unb) begin
         hi_q <= 7'h00;
      end else begin
         hi_q <= hi_q + 7'h01;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_size_onehot: assert property (
      $onehot({size_small_o, size_medium_o, size_large_o}))
      else $error("size outputs not one-hot");
   a_size_change: assert property (
      !$stable({size_small_o, size_medium_o, size_large_o}) |-> fw || $past(fw))
      else $error("size changed without a function write");
   a_x_update: assert property (
      !$stable(x_coord_o) |-> ($past(xw) && x_coord_o == $past(dlo))
      || x_coord_o == $past(x_coord_o) + inc)
      else $error("x moved by neither load nor size step");
   a_y_load: assert property (
      !$stable(y_coord_o) |-> $past(yw) && y_coord_o == $past(dlo))
      else $error("y changed without a y word");
   a_astig_rise: assert property (
      $rose(astig_o) |-> $past(yw))
      else $error("astigmatism rose without a y word");
   a_unblank_astig: assert property (unb |-> astig_o)
      else $error("unblank outside dot display");
   a_unblank_len: assert property (
      (unb |-> hi_q < vwd_pkg::DOT_CYC)
      and ($fell(unb) |-> hi_q == vwd_pkg::DOT_CYC))
      else $error("unblank pulse length wrong");
   a_kbd_upper: assert property (
      ack_o && !we_i && adr_i == vwd_pkg::ADR_DATA |-> dat_o[31:6] == 26'h0)
      else $error("keyboard reply upper bits set");
endmodule // vwd_decoder_sva

bind vwd_decoder vwd_decoder_sva u_sva (.clk_i(clk_i), .rst_i(rst_i),
   .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
   .x_coord_o(x_coord_o), .y_coord_o(y_coord_o),
   .size_small_o(size_small_o), .size_medium_o(size_medium_o),
   .size_large_o(size_large_o), .astig_o(astig_o),
   .unblank_left_o(unblank_left_o), .unblank_right_o(unblank_right_o));

// >>> tb/vwd_console_kbd.sv
module vwd_console_kbd (
   // Clock
   input wire logic clk_i,
   // Key request from the bench
   input wire logic press_i,
   input wire logic [5:0] code_i,
   // Keyboard lines toward the decoder
   output logic key_down_o,
   output logic [5:0] key_data_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] hold_q = 4'h0;
   logic [5:0] code_q = 6'h00;
   // Key held six cycles, code steady while down
   always_ff @(posedge clk_i) begin
      if (press_i) begin
         hold_q <= 4'h6;
         code_q <= code_i;
      end else if (hold_q != 4'h0) begin
         hold_q <= hold_q - 4'h1;
      end
   end
   assign key_down_o = hold_q != 4'h0;
   // Released lines show the inverted last code
   assign key_data_o = key_down_o ? code_q : ~code_q;
endmodule // vwd_console_kbd

// >>> tb/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, press = 1'b0;
   logic [3:0] adr_i = 4'h0, sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o, rd;
   logic [5:0] code = 6'h00, key_data_i;
   logic ack_o, err_o, key_down_i, got_err;
   logic [8:0] x_coord_o, y_coord_o, e;
   logic size_small_o, size_medium_o, size_large_o, screen_right_o;
   logic astig_o, unblank_left_o, unblank_right_o;
   logic [4:0] beam_dx_o, beam_dy_o;
   logic [1:0] side = 2'b00;
   int n_mismatch = 0, checked = 0, cycles = 0, n_unb = 0;
   logic [15:0] fcode [16] = '{16'h0E00, 16'h0E01, 16'h0E02, 16'h0E40,
      16'h0F00, 16'h0E08, 16'h0E10, 16'h8E04, 16'h8E05, 16'h8E06, 16'h8E44,
      16'h8F04, 16'h8E08, 16'h8E14, 16'h0600, 16'h8D04};
   logic [7:0] fexp [16] = '{8'h80, 8'h81, 8'h82, 8'h90, 8'hA0, 8'h84,
      8'h88, 8'hC0, 8'hC1, 8'hC2, 8'hD0, 8'hE0, 8'hC4, 8'hC8, 8'h00, 8'h00};

   vwd_decoder uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
      .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
      .key_down_i(key_down_i), .key_data_i(key_data_i),
      .x_coord_o(x_coord_o), .y_coord_o(y_coord_o),
      .size_small_o(size_small_o), .size_medium_o(size_medium_o),
      .size_large_o(size_large_o), .screen_right_o(screen_right_o),
      .astig_o(astig_o), .unblank_left_o(unblank_left_o),
      .unblank_right_o(unblank_right_o), .beam_dx_o(beam_dx_o),
      .beam_dy_o(beam_dy_o));
   vwd_console_kbd kbd (.clk_i(clk_i), .press_i(press), .code_i(code),
      .key_down_o(key_down_i), .key_data_o(key_data_i));

   always #5 clk_i = ~clk_i;
   // Unblank cycles and screens seen since last cleared
   always @(posedge clk_i) begin
      if (unblank_left_o | unblank_right_o) n_unb++;
      side |= {unblank_right_o, unblank_left_o};
   end
   // Hang guard, far above the several hundred cycles needed
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("compared %0d mismatched %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Classic cycle; waits for the slave, no fixed latency assumed
   task automatic wb(input logic w, input logic [3:0] a,
      input logic [31:0] d);
      int k;
      k = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= 4'hF;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack_o !== 1'b1 && err_o !== 1'b1 && k < 300);
      rd = dat_o;
      got_err = err_o;
      if (k >= 300) chk("bus answer", 32'h1, 32'h0);
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic do_reset(input int n);
      rst_i <= 1'b1;
      repeat (n) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic wait_idle();
      int k;
      k = 0;
      do begin
         wb(1'b0, vwd_pkg::ADR_STATUS, 32'h0);
         k++;
      end while (rd[3] !== 1'b0 && k < 50);
   endtask

   task automatic t_reset_vals();
      chk("console", 32'h40, {7'h0, x_coord_o, y_coord_o, size_small_o,
         size_medium_o, size_large_o, screen_right_o, astig_o,
         unblank_left_o, unblank_right_o});
      wb(1'b0, vwd_pkg::ADR_STATUS, 32'h0);
      chk("status", 32'h0, rd);
      wb(1'b0, vwd_pkg::ADR_FUNC, 32'h0);
      chk("function", 32'h0, rd);
   endtask

   task automatic t_unconn();
      wb(1'b1, vwd_pkg::ADR_DATA, 32'h6C55);
      chk("x unconnected", 32'h0, {23'h0, x_coord_o});
      wb(1'b0, 4'h2, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, got_err});
   endtask

   task automatic t_func();
      for (int i = 0; i < 16; i++) begin
         wb(1'b1, vwd_pkg::ADR_FUNC, {16'h0, fcode[i]});
         wb(1'b0, vwd_pkg::ADR_FUNC, 32'h0);
         if (fexp[i] == 8'h00) begin
            chk("connect lost", 32'h0, {31'h0, rd[7]});
         end else begin
            chk("function", {24'h0, fexp[i]}, rd);
            chk("size", {29'h0, fexp[i][1:0] == 2'b00, fexp[i][0],
               fexp[i][1]}, {29'h0, size_small_o, size_medium_o,
               size_large_o});
            if (!fexp[i][5]) chk("screen", {31'h0, fexp[i][4]},
               {31'h0, screen_right_o});
         end
      end
   endtask

   // Start near the top so the small step wraps past 511
   task automatic t_char();
      for (int s = 0; s < 3; s++) begin
         wb(1'b1, vwd_pkg::ADR_FUNC, 32'h0E00 | s);
         wb(1'b1, vwd_pkg::ADR_DATA, 32'h6DF0);
         chk("x load", 32'h1F0, {23'h0, x_coord_o});
         wb(1'b1, vwd_pkg::ADR_DATA, 32'h7F55);
         chk("y load", 32'h155, {23'h0, y_coord_o});
         wb(1'b1, vwd_pkg::ADR_DATA, 32'h0042);
         wait_idle();
         e = 9'h1F0 + (9'h010 << s);
         chk("x advance", {23'h0, e}, {23'h0, x_coord_o});
         chk("y held", 32'h155, {23'h0, y_coord_o});
         chk("beam rest", 32'h0, {22'h0, beam_dx_o, beam_dy_o});
      end
   endtask

   task automatic t_dot();
      for (int r = 0; r < 2; r++) begin
         wb(1'b1, vwd_pkg::ADR_FUNC, r ? 32'h0E48 : 32'h0E08);
         wb(1'b1, vwd_pkg::ADR_DATA, 32'h6CAA);
         n_unb = 0;
         side = 2'b00;
         wb(1'b1, vwd_pkg::ADR_DATA, 32'h7F33);
         chk("dot xy", 32'h00AA0133,
            {7'h0, x_coord_o, 7'h0, y_coord_o});
         chk("astig", 32'h1, {31'h0, astig_o});
         repeat (100) @(posedge clk_i);
         chk("dot pulse", 32'd40, n_unb);
         chk("dot side", r ? 32'h2 : 32'h1, {30'h0, side});
      end
   endtask

   task automatic t_kbd();
      wb(1'b1, vwd_pkg::ADR_FUNC, 32'h0E10);
      wb(1'b0, vwd_pkg::ADR_DATA, 32'h0);
      chk("kbd empty", 32'h0, rd);
      press <= 1'b1;
      code <= 6'h15;
      @(posedge clk_i);
      press <= 1'b0;
      repeat (10) @(posedge clk_i);
      wb(1'b0, vwd_pkg::ADR_STATUS, 32'h0);
      chk("kbd full", 32'h1, {31'h0, rd[1]});
      wb(1'b0, vwd_pkg::ADR_DATA, 32'h0);
      chk("kbd char", 32'h15, rd);
      wb(1'b0, vwd_pkg::ADR_DATA, 32'h0);
      chk("kbd drained", 32'h0, rd);
   endtask

   initial begin
      do_reset(10);
      t_reset_vals();
      t_unconn();
      t_func();
      t_char();
      t_dot();
      t_kbd();
      wb(1'b1, vwd_pkg::ADR_FUNC, 32'h0E02);
      do_reset(5);
      t_reset_vals();
      stop_test();
   end
endmodule // tb
